// ===== logic/pack_layout_config.sv
// Pack layout register, switch-matrix decode and scan settling delay
// How it works
// - With flex-pack enabled and an agreed top-cell code of 0x8..0xE, the supply input connects to the cell switch pin of that index.
// - Top-cell codes 0x0..0x7 and 0xF open all supply selection switches and keep the common switch closed, which is the default.
// - The block tap field in bits 11:8 picks the divider's sense pin, and codes 0x0..0x7 act as 0xF, the block sense pin.
// - Block tap codes 0x8..0xE choose the matching cell sense pin.
// - With the effective flex enable at 0 the tap field is ignored and the block sense pin is used.
// - The block tap setting is decoded apart from the top-cell setting.
// - With the settle bit (bit 13, reset 1) set, an alternate-path scan waits 30 us before sampling the top cell, only in flex mode with a valid top cell.
// - The delay applies only when flex is enabled, the agreed top cell is 0x8..0xE and alternate-path select is 1.
// - Disagreeing top-cell copies mask no balance-switch alerts and force the supply selector off.
// - An agreed top-cell code of 0xF masks no balance-switch alerts and puts the supply selector off.
// - Alert masking follows the agreed top-cell code whatever the enable, supply selection only while enabled.
// - Bit 15 holds the second flex enable copy, reset 1, where 1 enables top-cell and block selection.
// - Top-cell copies sit in bits 3:0 and 7:4 and both reset to 0xF.
// - Disagreeing enable copies count as enabled but force the supply selector off.
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module pack_layout_config (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                reset,
  // Avalon-MM slave
  input  wire logic [7:0]                          address,
  input  wire logic                                read,
  input  wire logic                                write,
  input  wire logic [3:0]                          byteenable,
  input  wire logic [31:0]                         writedata,
  output logic      [31:0]                         readdata,
  output logic                                     waitrequest,
  // Scan engine handshake
  input  wire logic                                scanStart,
  input  wire logic                                altPathSelect,
  output logic                                     sampleGo,
  output logic                                     settleBusy,
  // Switch matrix controls
  output logic [pack_cfg_pkg::SUPPLY_SW_COUNT-1:0] supplySwitchOn,
  output logic                                     supplyCommonOn,
  output logic [pack_cfg_pkg::FIELD_W-1:0]         blockTapSelect,
  output logic [pack_cfg_pkg::CELL_COUNT-1:0]      balanceAlertMask,
  // Interrupt
  output logic                                     irq
);
  import pack_cfg_pkg::*;

  // Stored register bits and interrupt state
  logic [CONFIG_W-1:0]        config_r;
  logic [CONFIG_W-1:0]        config_nxt;
  logic [IRQ_W-1:0]           status_r;
  logic [IRQ_W-1:0]           status_nxt;
  logic [IRQ_W-1:0]           mask_r;
  logic [IRQ_W-1:0]           mask_nxt;
  logic                       cellMism_r;
  logic                       enMism_r;

  // Bus handshake state
  logic                       ack_r;
  logic [31:0]                readdata_r;
  logic [31:0]                readdata_nxt;

  // Settle counter state
  logic [SETTLE_CNT_W-1:0]    settle_r;
  logic [SETTLE_CNT_W-1:0]    settle_nxt;
  logic                       busy_r;
  logic                       busy_nxt;
  logic                       sampleGo_r;
  logic                       sampleGo_nxt;

  // Registered switch-matrix controls
  logic [SUPPLY_SW_COUNT-1:0] supplyOn_r;
  logic                       commonOn_r;
  logic [FIELD_W-1:0]         tap_r;
  logic [CELL_COUNT-1:0]      alertMask_r;

  // Decoded fields
  logic [FIELD_W-1:0]         cellA;
  logic [FIELD_W-1:0]         cellB;
  logic [FIELD_W-1:0]         tapCode;
  logic                       enA;
  logic                       enB;
  logic                       settleEn;

  // Qualified selections
  logic                       cellAgree;
  logic                       enAgree;
  logic                       flexOn;
  logic                       cellInRange;
  logic                       cellValid;
  logic                       tapValid;
  logic                       supplySel;
  logic [FIELD_W-1:0]         supplyIdx;
  logic [SUPPLY_SW_COUNT-1:0] supplyOnNxt;
  logic [CELL_COUNT-1:0]      alertMaskNxt;
  logic [FIELD_W-1:0]         tapNxt;

  // Scan qualification
  logic                       scanTake;
  logic                       delayApplies;
  logic                       settleLast;

  // Bus decode
  logic                       req;
  logic                       accept;
  logic                       hitCfg;
  logic                       hitSts;
  logic                       hitMsk;
  logic                       doWrite;
  logic                       wrCfg;
  logic                       wrSts;
  logic                       wrMsk;
  logic [CONFIG_W-1:0]        beMask;
  logic [CONFIG_W-1:0]        cfgWr;
  logic [IRQ_W-1:0]           w1c;
  logic [31:0]                rdMux;
  logic [IRQ_W-1:0]           events;

  // Field extraction
  assign cellA    = config_r[CELL_A_LSB +: FIELD_W];
  assign cellB    = config_r[CELL_B_LSB +: FIELD_W];
  assign tapCode  = config_r[TAP_LSB +: FIELD_W];
  assign enA      = config_r[ENABLE_A_BIT];
  assign enB      = config_r[ENABLE_B_BIT];
  assign settleEn = config_r[SETTLE_BIT];

  // Redundant copy checks; a disagreeing enable reads as enabled
  assign cellAgree   = (cellA == cellB);
  assign enAgree     = (enA == enB);
  assign flexOn      = enAgree ? enA : 1'b1;
  assign cellInRange = (cellA >= CODE_MIN) && (cellA <= CODE_MAX);
  assign cellValid   = cellAgree && cellInRange;
  assign tapValid    = (tapCode >= CODE_MIN) && (tapCode <= CODE_MAX);

  // Supply selector closes only when every check passes; a split enable
  // still feeds the tap but must never leave a supply switch closed
  assign supplySel = flexOn && enAgree && cellValid;
  assign supplyIdx = cellA - CODE_MIN;

  // Supply switch decode, one switch per supported top-cell code
  genvar gi;
  generate
    for (gi = 0; gi < SUPPLY_SW_COUNT; gi++) begin : g_sup
      assign supplyOnNxt[gi] = supplySel
        && (supplyIdx == FIELD_W'(gi));
    end
    // Channels above the agreed top cell have their alerts masked
    for (gi = 0; gi < CELL_COUNT; gi++) begin : g_msk
      assign alertMaskNxt[gi] = cellAgree && (cellA != CODE_OFF)
        && (FIELD_W'(gi + 1) > cellA);
    end
  endgenerate

  // Block tap decode kept apart from the top-cell path
  assign tapNxt =
    (flexOn && tapValid) ? tapCode : CODE_OFF;

  // Settling delay qualification
  assign scanTake     = scanStart && !busy_r;
  assign delayApplies = settleEn && flexOn && cellValid
                        && altPathSelect;
  assign settleLast   = busy_r
    && (settle_r == SETTLE_CNT_W'(SETTLE_CYCLES - 1));

  // A transfer lands on the edge where waitrequest is already low
  assign req     = (read || write) && !ack_r;
  assign accept  = (read || write) && ack_r;
  assign doWrite = write && accept;
  assign beMask  = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  // Address decode, one register per address
  always_comb begin
    hitCfg = 1'b0;
    hitSts = 1'b0;
    hitMsk = 1'b0;
    if (address == PACK_LAYOUT_CONFIG_ADDR) begin
      hitCfg = 1'b1;
    end else if (address == IRQ_STATUS_ADDR) begin
      hitSts = 1'b1;
    end else if (address == IRQ_MASK_ADDR) begin
      hitMsk = 1'b1;
    end
  end

  // Write strobes and merged write data; reserved bit stays zero
  assign wrCfg = doWrite && hitCfg;
  assign wrSts = doWrite && hitSts && byteenable[0];
  assign wrMsk = doWrite && hitMsk && byteenable[0];
  assign cfgWr = (config_r & ~(beMask & CONFIG_WMASK))
               | (writedata[CONFIG_W-1:0] & beMask & CONFIG_WMASK);
  assign w1c        = wrSts ? writedata[IRQ_W-1:0] : '0;
  assign config_nxt = wrCfg ? cfgWr : config_r;
  assign mask_nxt   = wrMsk ? writedata[IRQ_W-1:0] : mask_r;

  // Read data selection; unmapped addresses read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitCfg) begin
      rdMux = {16'h0000, config_r};
    end else if (hitSts) begin
      rdMux = {{(32-IRQ_W){1'b0}}, status_r};
    end else if (hitMsk) begin
      rdMux = {{(32-IRQ_W){1'b0}}, mask_r};
    end
  end
  assign readdata_nxt = req ? rdMux : readdata_r;

  // Events: new mismatches and settle completion; set beats clear
  assign events[EV_CELL_MISM]   = !cellAgree && !cellMism_r;
  assign events[EV_ENABLE_MISM] = !enAgree && !enMism_r;
  assign events[EV_SETTLE_DONE] = settleLast;
  assign status_nxt = (status_r & ~w1c) | events;

  // One wait cycle per access so read data is registered
  assign waitrequest = (read || write) && !ack_r;
  assign readdata    = readdata_r;

  // Bus handshake
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_r      <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      ack_r      <= req;
      readdata_r <= readdata_nxt;
    end
  end

  // Stored register bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      config_r <= CONFIG_RESET;
      mask_r   <= '0;
    end else begin
      config_r <= config_nxt;
      mask_r   <= mask_nxt;
    end
  end

  // Interrupt status and mismatch history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_r   <= '0;
      cellMism_r <= 1'b0;
      enMism_r   <= 1'b0;
    end else begin
      status_r   <= status_nxt;
      cellMism_r <= !cellAgree;
      enMism_r   <= !enAgree;
    end
  end

  // Settle counter next state; a start while busy is ignored so that
  // a running wait is never cut short
  always_comb begin
    busy_nxt     = busy_r;
    settle_nxt   = settle_r;
    sampleGo_nxt = settleLast;
    if (scanTake && delayApplies) begin
      busy_nxt   = 1'b1;
      settle_nxt = '0;
    end else if (scanTake) begin
      sampleGo_nxt = 1'b1;
    end else if (settleLast) begin
      busy_nxt = 1'b0;
    end else if (busy_r) begin
      settle_nxt = settle_r + 1'b1;
    end
  end

  // Settle counter registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_r     <= 1'b0;
      settle_r   <= '0;
      sampleGo_r <= 1'b0;
    end else begin
      busy_r     <= busy_nxt;
      settle_r   <= settle_nxt;
      sampleGo_r <= sampleGo_nxt;
    end
  end

  // Decoded controls registered so the switch lines never glitch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      supplyOn_r  <= '0;
      commonOn_r  <= 1'b1;
      tap_r       <= CODE_OFF;
      alertMask_r <= '0;
    end else begin
      supplyOn_r  <= supplyOnNxt;
      commonOn_r  <= !supplySel;
      tap_r       <= tapNxt;
      alertMask_r <= alertMaskNxt;
    end
  end

  assign supplySwitchOn   = supplyOn_r;
  assign supplyCommonOn   = commonOn_r;
  assign blockTapSelect   = tap_r;
  assign balanceAlertMask = alertMask_r;
  assign sampleGo         = sampleGo_r;
  assign settleBusy       = busy_r;
  assign irq              = |(status_r & mask_r);
endmodule

// ===== include/pack_cfg_pkg.sv
// Constants for the pack layout configuration block
package pack_cfg_pkg;
  // Register byte addresses on the Avalon-MM slave
  localparam logic [7:0] PACK_LAYOUT_CONFIG_ADDR = 8'h18;
  localparam logic [7:0] IRQ_STATUS_ADDR         = 8'h1c;
  localparam logic [7:0] IRQ_MASK_ADDR           = 8'h20;

  // Field positions in pack_layout_config
  localparam int ENABLE_B_BIT  = 15;
  localparam int ENABLE_A_BIT  = 14;
  localparam int SETTLE_BIT    = 13;
  localparam int TAP_LSB       = 8;
  localparam int CELL_B_LSB    = 4;
  localparam int CELL_A_LSB    = 0;
  localparam int FIELD_W       = 4;
  localparam int CONFIG_W      = 16;

  // Reset value: both enables, settle delay, all codes 0xF
  localparam logic [15:0] CONFIG_RESET = 16'hefff;
  localparam logic [15:0] CONFIG_WMASK = 16'hefff; // Bit 12 reserved

  // Cell code range that the selectors support
  localparam logic [3:0] CODE_MIN = 4'h8;
  localparam logic [3:0] CODE_MAX = 4'he;
  localparam logic [3:0] CODE_OFF = 4'hf;
  localparam int         CELL_COUNT = 14;
  localparam int         SUPPLY_SW_COUNT = 7;

  // Interrupt status bit positions
  localparam int IRQ_W          = 3;
  localparam int EV_CELL_MISM   = 0;
  localparam int EV_ENABLE_MISM = 1;
  localparam int EV_SETTLE_DONE = 2;

  // Settling delay before the top-cell sample
  localparam int SETTLE_NS     = 30000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_CYCLES =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W  = 10;
endpackage

// ===== verif/pack_layout_config_chk.sv
// Port checker for the pack layout configuration block
`timescale 1ns/10ps
module pack_layout_config_chk (
  // Clock, reset and scan handshake
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        scanStart,
  input wire logic        sampleGo,
  input wire logic        settleBusy,
  // Switch matrix controls
  input wire logic [6:0]  supplySwitchOn,
  input wire logic        supplyCommonOn,
  input wire logic [3:0]  blockTapSelect,
  input wire logic [13:0] balanceAlertMask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Settle wait is 600 busy cycles, then one sample pulse
  sequence settle_end;
    ##[599:599] settleBusy ##1 (sampleGo && !settleBusy);
  endsequence
  a_common_off: assert property (
    supplyCommonOn == (supplySwitchOn == 7'h0)) else $error("common bad");
  a_switch_single: assert property (
    $onehot0(supplySwitchOn)) else $error("two supply switches on");
  a_tap_valid: assert property (
    blockTapSelect >= 4'h8) else $error("tap code below 8");
  // Mask and switch come from the same agreed code
  a_mask_follows: assert property (supplySwitchOn != 7'h0 |->
    balanceAlertMask == (14'h3fff << (8 + $clog2(supplySwitchOn))))
    else $error("mask disagrees with switch");
  a_go_pulse: assert property (
    sampleGo && !scanStart |=> !sampleGo) else $error("go too long");
  a_settle_len: assert property (
    $rose(settleBusy) |-> settle_end) else $error("settle length");
  a_scan_answer: assert property (
    scanStart && !settleBusy |=> sampleGo != settleBusy)
    else $error("scan not answered");
  a_busy_cause: assert property (
    $rose(settleBusy) |-> $past(scanStart)) else $error("busy uncaused");
endmodule
bind pack_layout_config pack_layout_config_chk pack_layout_config_chk_inst (
  .clk(clk), .reset(reset), .scanStart(scanStart), .sampleGo(sampleGo),
  .settleBusy(settleBusy), .supplySwitchOn(supplySwitchOn),
  .supplyCommonOn(supplyCommonOn), .blockTapSelect(blockTapSelect),
  .balanceAlertMask(balanceAlertMask));

// ===== verif/pack_layout_config_tb.sv
// Self-checking bench for the pack layout configuration block
`timescale 1ns/10ps
module pack_layout_config_tb;
  import pack_cfg_pkg::*;
  logic        clk, reset, read, write, scanStart, altPathSelect, irq;
  logic        waitrequest, sampleGo, settleBusy, supplyCommonOn;
  logic [31:0] writedata, readdata, q;
  logic [7:0]  address;
  logic [6:0]  supplySwitchOn, p;
  logic [3:0]  byteenable, blockTapSelect, c, t;
  logic [13:0] balanceAlertMask, m;
  logic [1:0]  e;
  int          fails, compares, n;
  pack_layout_config pack_layout_config_inst (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .scanStart(scanStart), .altPathSelect(altPathSelect),
    .sampleGo(sampleGo), .settleBusy(settleBusy),
    .supplySwitchOn(supplySwitchOn), .supplyCommonOn(supplyCommonOn),
    .blockTapSelect(blockTapSelect), .balanceAlertMask(balanceAlertMask),
    .irq(irq));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One transfer, held until waitrequest is sampled low at a rising edge;
  // the extra edge lets the decoded outputs follow a write
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 9);
    if (waitrequest !== 1'b0) check(1'b0, 1'b1);
    if (waitrequest !== 1'b0) finish_test();
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  // Pulse scanStart and count cycles up to the sample pulse
  task automatic scan(input logic alt, input int exp);
    @(posedge clk);
    scanStart <= 1'b1;
    altPathSelect <= alt;
    @(posedge clk);
    scanStart <= 1'b0;
    @(negedge clk);
    for (n = 1; n < 700 && sampleGo !== 1'b1; n++) @(negedge clk);
    check(n, exp);
    if (n == 700) finish_test();
  endtask
  // Reset, decode table over all codes, then mismatches, scans and irq
  initial begin
    fails = 0;
    compares = 0;
    {reset, read, write, scanStart, altPathSelect} = 5'h10;
    {address, byteenable, writedata} = {8'h0, 4'hf, 32'h0};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    check({supplyCommonOn, supplySwitchOn, blockTapSelect, balanceAlertMask,
      irq}, {1'b1, 7'h0, 4'hf, 14'h0, 1'b0});
    bus(1'b0, PACK_LAYOUT_CONFIG_ADDR, 32'h0);
    check(q, 32'hefff);
    for (int i = 0; i < 32; i++) begin
      c = i[3:0];
      t = ~c;
      e = i[4] ? 2'b11 : 2'b00;
      m = 14'h3fff << c;
      p = 7'h1 << (c - 4'h8);
      bus(1'b1, PACK_LAYOUT_CONFIG_ADDR, {16'h0, e, 2'b11, t, c, c});
      check(supplySwitchOn, (i[4] && c >= 8 && c <= 14) ? p : 7'h0);
      check(blockTapSelect, (i[4] && t >= 8) ? t : 4'hf);
      check(balanceAlertMask, c == 4'hf ? 14'h0 : m);
      bus(1'b0, PACK_LAYOUT_CONFIG_ADDR, 32'h0);
      check(q, {16'h0, e, 2'b10, t, c, c});
    end
    bus(1'b1, PACK_LAYOUT_CONFIG_ADDR, 32'hef89);
    check({supplySwitchOn, balanceAlertMask}, 21'h0);
    bus(1'b1, PACK_LAYOUT_CONFIG_ADDR, 32'h6a99);
    check({supplySwitchOn, blockTapSelect, balanceAlertMask},
      {7'h0, 4'ha, 14'h3e00});
    scan(1'b1, 601);
    scan(1'b0, 1);
    bus(1'b1, PACK_LAYOUT_CONFIG_ADDR, 32'h4a99);
    scan(1'b1, 1);
    bus(1'b1, PACK_LAYOUT_CONFIG_ADDR, 32'heaff);
    scan(1'b1, 1);
    bus(1'b0, IRQ_STATUS_ADDR, 32'h0);
    check({q, irq}, {32'h7, 1'b0});
    bus(1'b1, IRQ_MASK_ADDR, 32'h4);
    check(irq, 1'b1);
    bus(1'b1, IRQ_STATUS_ADDR, 32'h7);
    check(irq, 1'b0);
    bus(1'b0, IRQ_STATUS_ADDR, 32'h0);
    check(q, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    check(q, 32'h0);
    finish_test();
  end
endmodule
